// *** src/irs_sequencer.sv ***
// Purpose: Interrupt and reset sequencing beside an 8-bit processor core.
// Assumes: Peripheral flags and enables arrive as levels; core events are one-cycle pulses.
// Notes: The core performs the stacking itself; this block requests it and waits for done.
//
// Summary of operation
// [RULE1] Six hardware sources plus one software trap.
// [RULE2] Taking interrupt pushes registers, then sets mask.
// [RULE3] Return instruction pulls saved registers, resumes.
// [RULE4] Requests wait for the current instruction end.
// [RULE5] Boundary services unmasked, enabled requests only.
// [RULE6] Software trap ignores mask, vector 1FFC.
// [RULE7] Software trap after older, before newer requests.
// [RULE8] Mask bit gates every maskable source.
// [RULE9] External falling edge latched, synchronised, vector 1FFA.
// [RULE10] Timer two bit three picks trigger mode.
// [RULE11] External latch cleared early in service.
// [RULE12] Timer one three flags share 1FF8.
// [RULE13] Async serial five flags share 1FF6.
// [RULE14] Sync serial two flags share 1FF4.
// [RULE15] Two-wire event flag uses vector 1FF2.
// [RULE16] Timer two two flags share 1FF0.
// [RULE17] Reset pin sets mask, starts at 1FFE.
// [RULE18] Stop halts oscillator until external request or reset.
// [RULE19] Wait stops core clocks, timers keep running.
// [RULE20] Power-up holds reset 4064 cycles, extends while pin low.
// [RULE21] Reset pin held low one and half cycles.
// [RULE22] Watchdog timeout resets, keeps current operating mode.
// [RULE23] Higher vector address wins among pending requests.
`timescale 1ns/1ns
module irs_sequencer
#(
   parameter int POR_CYCLES = irs_pkg::POR_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic reset_pin_b,
   input wire logic irq_pin_b,
   input wire logic mode_strap,
   input wire logic wdog_enable,
   input wire logic wdog_timeout,
   input wire logic instr_done,
   input wire logic soft_trap_instr,
   input wire logic return_from_trap_instr,
   input wire logic stop_instr,
   input wire logic wait_instr,
   input wire logic mask_set_req,
   input wire logic mask_clr_req,
   input wire logic stack_push_done,
   input wire logic stack_pull_done,
   input wire logic restored_mask,
   input wire logic input_capture_flag,
   input wire logic output_compare_flag,
   input wire logic timer_one_overflow_flag,
   input wire logic input_capture_en,
   input wire logic output_compare_en,
   input wire logic timer_one_overflow_en,
   input wire logic tx_buffer_empty_flag,
   input wire logic tx_complete_flag,
   input wire logic rx_buffer_full_flag,
   input wire logic idle_line_flag,
   input wire logic overrun_flag,
   input wire logic tx_buffer_empty_en,
   input wire logic tx_complete_en,
   input wire logic rx_buffer_full_en,
   input wire logic idle_line_en,
   input wire logic overrun_en,
   input wire logic sync_transfer_done_flag,
   input wire logic sync_mode_fault_flag,
   input wire logic sync_en,
   input wire logic twowire_event_flag,
   input wire logic twowire_en,
   input wire logic timer_two_overflow_flag,
   input wire logic timer_two_tick_flag,
   input wire logic timer_two_overflow_en,
   input wire logic timer_two_tick_en,
   input wire logic [7:0] timer_two_ctrl_status_reg,
   output logic global_mask,
   output logic core_reset,
   output logic push_regs,
   output logic pull_regs,
   output logic vector_valid,
   output logic [15:0] vector_addr,
   output logic osc_enable,
   output logic cpu_clk_enable,
   output logic timer_clk_enable,
   output logic op_mode
);

   localparam int POR_W = $clog2(POR_CYCLES + 1);
   localparam int PIN_W = $clog2(irs_pkg::RST_PIN_CYCLES + 1);
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES);
   localparam logic [PIN_W-1:0] PIN_LAST = PIN_W'(irs_pkg::RST_PIN_CYCLES);

   irs_pkg::irs_state_t state;
   irs_pkg::irs_state_t next_state;

   logic pin_s1;
   logic pin_s2;
   logic [PIN_W-1:0] pin_low_count;
   logic [POR_W-1:0] por_count;
   logic por_busy;
   logic pin_reset;
   logic wdog_fire;
   logic reset_cond;
   logic wdog_caused;
   logic ext_pending;
   logic ext_clear;
   logic [5:0] src_req;
   logic [5:0] eligible;
   logic [5:0] soft_snap;
   logic soft_pending;
   logic boundary;
   logic take_soft;
   logic take_hw;
   logic [5:0] hw_pick_set;
   logic [15:0] pend_vec;
   logic pend_soft;

   function automatic logic [15:0] irs_pick_vector(input logic [5:0] req);
      logic [15:0] v;
      v = irs_pkg::VEC_TIMER_TWO;
      if (req[irs_pkg::SRC_EXT])
         v = irs_pkg::VEC_EXT;
      else if (req[irs_pkg::SRC_TIMER_ONE])
         v = irs_pkg::VEC_TIMER_ONE;
      else if (req[irs_pkg::SRC_ASYNC])
         v = irs_pkg::VEC_ASYNC;
      else if (req[irs_pkg::SRC_SYNC])
         v = irs_pkg::VEC_SYNC;
      else if (req[irs_pkg::SRC_TWOWIRE])
         v = irs_pkg::VEC_TWOWIRE;
      return v;
   endfunction

   // Reset pin: synchronise, then demand a minimum low time to reject glitches.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         pin_low_count <= '0;
      end
      else if (clk_en)
      begin
         pin_s1 <= reset_pin_b;
         pin_s2 <= pin_s1;
         if (pin_s2)
            pin_low_count <= '0;
         else if (pin_low_count != PIN_LAST)
            pin_low_count <= pin_low_count + 1'b1; // see [RULE21]
      end
   end

   // Power-on delay counts from the release of the power-on reset.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         por_count <= '0;
      else if (clk_en && por_busy)
         por_count <= por_count + 1'b1; // see [RULE20]
   end

   assign por_busy = (por_count != POR_LAST);
   assign pin_reset = (pin_low_count == PIN_LAST);
   assign wdog_fire = wdog_timeout & wdog_enable; // see [RULE22]
   // Pin low at the end of the delay simply keeps the reset asserted.
   assign reset_cond = por_busy | pin_reset | wdog_fire; // see [RULE17] [RULE20]

   // A watchdog reset must not re-sample the mode strap.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         core_reset <= 1'b1;
         wdog_caused <= 1'b0;
         op_mode <= 1'b0;
      end
      else if (clk_en)
      begin
         core_reset <= reset_cond;
         if (por_busy || pin_reset)
            wdog_caused <= 1'b0;
         else if (wdog_fire)
            wdog_caused <= 1'b1;
         if (state == irs_pkg::IRS_ST_RESET && !reset_cond && !wdog_caused)
            op_mode <= mode_strap; // see [RULE22]
      end
   end

   irs_ext_latch u_ext_latch
   (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .irq_pin_b(irq_pin_b),
      .level_mode(timer_two_ctrl_status_reg[irs_pkg::T2_TRIGGER_BIT]),
      .clear(ext_clear),
      .pending(ext_pending)
   );

   // Source requests: the external latch, or any other flag set with its enable set.
   always_comb
   begin
      src_req = '0;
      src_req[irs_pkg::SRC_EXT] = ext_pending; // see [RULE1]
      src_req[irs_pkg::SRC_TIMER_ONE] = (input_capture_flag & input_capture_en)
         | (output_compare_flag & output_compare_en)
         | (timer_one_overflow_flag & timer_one_overflow_en); // see [RULE12]
      src_req[irs_pkg::SRC_ASYNC] = (tx_buffer_empty_flag & tx_buffer_empty_en)
         | (tx_complete_flag & tx_complete_en) | (rx_buffer_full_flag & rx_buffer_full_en)
         | (idle_line_flag & idle_line_en) | (overrun_flag & overrun_en); // see [RULE13]
      src_req[irs_pkg::SRC_SYNC] = (sync_transfer_done_flag | sync_mode_fault_flag) & sync_en; // see [RULE14]
      src_req[irs_pkg::SRC_TWOWIRE] = twowire_event_flag & twowire_en; // see [RULE15]
      src_req[irs_pkg::SRC_TIMER_TWO] = (timer_two_overflow_flag & timer_two_overflow_en)
         | (timer_two_tick_flag & timer_two_tick_en); // see [RULE16]
   end

   assign eligible = src_req & {irs_pkg::SRC_COUNT{~global_mask}}; // see [RULE8]
   // In run, only the end of the executing instruction is a point of service; stop and wait take a request at once.
   assign boundary = clk_en && state == irs_pkg::IRS_ST_RUN && instr_done; // see [RULE4]
   // Requests older than the trap go first; newer ones wait behind it.
   assign hw_pick_set = soft_pending ? (eligible & soft_snap) : eligible; // see [RULE7]
   assign take_hw = boundary && (|hw_pick_set); // see [RULE5]
   assign take_soft = boundary && soft_pending && !(|hw_pick_set); // see [RULE6]

   // Software trap bookkeeping.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         soft_pending <= 1'b0;
         soft_snap <= '0;
      end
      else if (clk_en)
      begin
         // Internal reset drops a fetched trap, but only on an enabled cycle so a frozen block stays frozen.
         if (reset_cond)
         begin
            soft_pending <= 1'b0;
            soft_snap <= '0;
         end
         else if (soft_trap_instr)
         begin
            soft_pending <= 1'b1;
            soft_snap <= eligible; // see [RULE7]
         end
         else if (take_soft)
            soft_pending <= 1'b0;
      end
   end

   // Pending service choice, frozen while registers are pushed.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pend_vec <= irs_pkg::VEC_RESET;
         pend_soft <= 1'b0;
      end
      else if (clk_en)
      begin
         if (take_soft)
         begin
            pend_vec <= irs_pkg::VEC_SOFT; // see [RULE6]
            pend_soft <= 1'b1;
         end
         else if (take_hw)
         begin
            pend_vec <= irs_pick_vector(hw_pick_set); // see [RULE23]
            pend_soft <= 1'b0;
         end
         else if ((state == irs_pkg::IRS_ST_STOP && ext_pending)
            || (state == irs_pkg::IRS_ST_WAIT && (|eligible)))
         begin
            pend_vec <= irs_pick_vector(eligible); // see [RULE18] [RULE19]
            pend_soft <= 1'b0;
         end
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         irs_pkg::IRS_ST_RESET:
            if (!reset_cond)
               next_state = irs_pkg::IRS_ST_RUN;
         irs_pkg::IRS_ST_RUN:
            if (take_hw || take_soft)
               next_state = irs_pkg::IRS_ST_PUSH; // see [RULE2]
            else if (return_from_trap_instr)
               next_state = irs_pkg::IRS_ST_PULL; // see [RULE3]
            else if (stop_instr)
               next_state = irs_pkg::IRS_ST_STOP;
            else if (wait_instr)
               next_state = irs_pkg::IRS_ST_WAIT;
         irs_pkg::IRS_ST_PUSH:
            if (stack_push_done)
               next_state = irs_pkg::IRS_ST_RUN;
         irs_pkg::IRS_ST_PULL:
            if (stack_pull_done)
               next_state = irs_pkg::IRS_ST_RUN;
         irs_pkg::IRS_ST_STOP:
            if (ext_pending)
               next_state = irs_pkg::IRS_ST_PUSH; // see [RULE18]
         irs_pkg::IRS_ST_WAIT:
            if (|eligible)
               next_state = irs_pkg::IRS_ST_PUSH; // see [RULE19]
         default:
            next_state = irs_pkg::IRS_ST_RESET;
      endcase
      if (reset_cond)
         next_state = irs_pkg::IRS_ST_RESET;
   end

   // Clock gates follow the next state so they switch together with it.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= irs_pkg::IRS_ST_RESET;
         osc_enable <= 1'b1;
         cpu_clk_enable <= 1'b1;
         timer_clk_enable <= 1'b1;
         push_regs <= 1'b0;
         pull_regs <= 1'b0;
      end
      else if (clk_en)
      begin
         state <= next_state;
         osc_enable <= (next_state != irs_pkg::IRS_ST_STOP); // see [RULE18]
         cpu_clk_enable <= (next_state != irs_pkg::IRS_ST_STOP) && (next_state != irs_pkg::IRS_ST_WAIT);
         timer_clk_enable <= (next_state != irs_pkg::IRS_ST_STOP); // see [RULE19]
         push_regs <= (next_state == irs_pkg::IRS_ST_PUSH);
         pull_regs <= (next_state == irs_pkg::IRS_ST_PULL);
      end
   end

   assign ext_clear = clk_en && state == irs_pkg::IRS_ST_PUSH && stack_push_done
      && !pend_soft && pend_vec == irs_pkg::VEC_EXT; // see [RULE11]

   // Vector handoff and mask ownership.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         global_mask <= 1'b1;
         vector_valid <= 1'b0;
         vector_addr <= irs_pkg::VEC_RESET;
      end
      else if (clk_en)
      begin
         vector_valid <= 1'b0;
         if (reset_cond)
         begin
            global_mask <= 1'b1; // see [RULE17]
            vector_addr <= irs_pkg::VEC_RESET;
         end
         else if (state == irs_pkg::IRS_ST_RESET)
            vector_valid <= 1'b1; // see [RULE17]
         else if (state == irs_pkg::IRS_ST_PUSH && stack_push_done)
         begin
            global_mask <= 1'b1; // see [RULE2]
            vector_addr <= pend_vec;
            vector_valid <= 1'b1;
         end
         else if (state == irs_pkg::IRS_ST_PULL && stack_pull_done)
            global_mask <= restored_mask; // see [RULE3]
         else if (state == irs_pkg::IRS_ST_RUN && (stop_instr || wait_instr) && !take_hw && !take_soft
            && !return_from_trap_instr)
            global_mask <= 1'b0;
         else if (state == irs_pkg::IRS_ST_RUN && mask_set_req)
            global_mask <= 1'b1; // see [RULE8]
         else if (state == irs_pkg::IRS_ST_RUN && mask_clr_req)
            global_mask <= 1'b0; // see [RULE8]
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_take;
      clk_en && (take_hw || take_soft) && !reset_cond;
   endsequence

   sequence s_push_done;
      clk_en && push_regs && stack_push_done && !reset_cond;
   endsequence

   a_take_pushes: assert property (s_take |=> push_regs) // see [RULE2]
      else $error("taken interrupt did not request push");
   a_vec_sets_mask: assert property (s_push_done |=> vector_valid && global_mask) // see [RULE2]
      else $error("vector issued without mask set");
   a_pull_resumes: assert property (clk_en && pull_regs && stack_pull_done && !reset_cond
      |=> !pull_regs && global_mask == $past(restored_mask)) // see [RULE3]
      else $error("return did not restore mask");
   a_masked_no_take: assert property (boundary && global_mask && !soft_pending |-> !take_hw) // see [RULE5]
      else $error("masked request taken");
   a_soft_vector: assert property (s_push_done ##0 pend_soft |=> vector_addr == irs_pkg::VEC_SOFT) // see [RULE6]
      else $error("software trap used wrong vector");
   a_ext_clear_vec: assert property (ext_clear |=> vector_addr == irs_pkg::VEC_EXT && vector_valid) // see [RULE11]
      else $error("external latch cleared outside its service");
   a_reset_holds: assert property (core_reset |-> global_mask && vector_addr == irs_pkg::VEC_RESET) // see [RULE17]
      else $error("reset without mask or reset vector");
   a_stop_osc: assert property (state == irs_pkg::IRS_ST_STOP |-> !osc_enable && !cpu_clk_enable) // see [RULE18]
      else $error("oscillator running in stop");
   a_wait_clocks: assert property (state == irs_pkg::IRS_ST_WAIT |-> timer_clk_enable && !cpu_clk_enable) // see [RULE19]
      else $error("wrong clocks in wait");
   a_por_hold: assert property (por_busy && clk_en |=> core_reset) // see [RULE20]
      else $error("power-on delay not held");
   a_wdog_reset: assert property (clk_en && wdog_fire |=> core_reset && $stable(op_mode)) // see [RULE22]
      else $error("watchdog did not reset or mode changed");

endmodule

// *** src/irs_pkg.sv ***
// Purpose: Shared constants and types for the interrupt and reset sequencer.
// Assumes: One processor clock at 100 MHz drives all logic.
// Notes: Vector constants are the high byte address of each two-byte vector.
package irs_pkg;

   // Vector addresses, high byte at the given address, low byte one above.
   localparam logic [15:0] VEC_RESET = 16'h1FFE;
   localparam logic [15:0] VEC_SOFT = 16'h1FFC;
   localparam logic [15:0] VEC_EXT = 16'h1FFA;
   localparam logic [15:0] VEC_TIMER_ONE = 16'h1FF8;
   localparam logic [15:0] VEC_ASYNC = 16'h1FF6;
   localparam logic [15:0] VEC_SYNC = 16'h1FF4;
   localparam logic [15:0] VEC_TWOWIRE = 16'h1FF2;
   localparam logic [15:0] VEC_TIMER_TWO = 16'h1FF0;

   // Hardware source positions in the request vector, highest priority on top.
   localparam int SRC_COUNT = 6;
   localparam int SRC_EXT = 5;
   localparam int SRC_TIMER_ONE = 4;
   localparam int SRC_ASYNC = 3;
   localparam int SRC_SYNC = 2;
   localparam int SRC_TWOWIRE = 1;
   localparam int SRC_TIMER_TWO = 0;

   // Trigger select position in the timer two control and status register.
   localparam int T2_TRIGGER_BIT = 3;

   // Timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_CYCLES = 4064;
   localparam int RST_PIN_MIN_NS = 15;
   localparam int RST_PIN_CYCLES = (RST_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [5:0] {
      IRS_ST_RESET = 6'h01,
      IRS_ST_RUN = 6'h02,
      IRS_ST_PUSH = 6'h04,
      IRS_ST_PULL = 6'h08,
      IRS_ST_STOP = 6'h10,
      IRS_ST_WAIT = 6'h20
   } irs_state_t;

endpackage

// *** src/irs_ext_latch.sv ***
// Purpose: Latch for the external interrupt request pin.
// Assumes: The pin is asynchronous and is synchronised here.
// Notes: A new edge in the clearing cycle keeps the request pending.
`timescale 1ns/1ns
module irs_ext_latch
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic irq_pin_b,
   input wire logic level_mode,
   input wire logic clear,
   output logic pending
);

   logic sync_a;
   logic sync_b;
   logic sync_prev;
   logic fall;
   logic set_req;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         sync_prev <= 1'b1;
      end
      else if (clk_en)
      begin
         sync_a <= irq_pin_b;
         sync_b <= sync_a;
         sync_prev <= sync_b;
      end
   end

   assign fall = sync_prev & ~sync_b;
   // Level mode keeps asking while the pin stays low, edge mode asks once.
   assign set_req = fall | (level_mode & ~sync_b); // see [RULE10]

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         pending <= 1'b0;
      else if (clk_en)
      begin
         if (set_req)
            pending <= 1'b1; // see [RULE9] [RULE11]
         else if (clear)
            pending <= 1'b0;
      end
   end

endmodule

// *** test/irs_core_model.sv ***
// Purpose: Core side of the stacking handshake for the interrupt sequencer.
// Assumes: One done pulse answers each push or pull request.
// Notes: Slow mode stretches the stacking time to catch sequencers that do not wait.
`timescale 1ns/1ns
module irs_core_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic push_regs,
   input wire logic pull_regs,
   input wire logic slow,
   output logic stack_push_done,
   output logic stack_pull_done
);
   logic [2:0] cnt;
   logic answered;
   // The request stays high one edge after done, so a second pulse is held off until it drops.
   always_ff @(posedge clk)
   begin
      if (!rst_b || !(push_regs || pull_regs))
      begin
         cnt <= 3'h0;
         answered <= 1'b0;
         stack_push_done <= 1'b0;
         stack_pull_done <= 1'b0;
      end
      else
      begin
         stack_push_done <= 1'b0;
         stack_pull_done <= 1'b0;
         if (!answered && cnt == (slow ? 3'h2 : 3'h0))
         begin
            stack_push_done <= push_regs;
            stack_pull_done <= pull_regs;
            answered <= 1'b1;
         end
         else if (!answered)
            cnt <= cnt + 3'h1;
      end
   end
endmodule

// *** test/irs_sequencer_bench.sv ***
// Purpose: Self-checking bench for the interrupt and reset sequencer.
// Assumes: Power-on delay shortened to 20 cycles.
// Notes: A vector is looked for in a fixed window, so a missing one reads as zero.
`timescale 1ns/1ns
module irs_sequencer_bench;
   typedef struct packed {logic [12:0] f; logic [12:0] e; logic clr; logic [15:0] v;} irs_row_t;
   logic clk, rst_b, clk_en, reset_pin_b, irq_pin_b, mode_strap, wdog_enable, wdog_timeout;
   logic instr_done, soft_trap_instr, return_from_trap_instr, stop_instr, wait_instr;
   logic mask_set_req, mask_clr_req, restored_mask, slow, stack_push_done, stack_pull_done;
   logic global_mask, core_reset, push_regs, pull_regs, vector_valid, osc_enable;
   logic cpu_clk_enable, timer_clk_enable, op_mode;
   logic [15:0] vector_addr;
   logic [15:0] got;
   logic [12:0] flg, en;
   logic [7:0] timer_two_ctrl_status_alias;
   int n_mismatch = 0;
   int check_count = 0;
   irs_row_t rows [17] = '{
      '{13'h0001, 13'h0001, 1'b1, 16'h1FF8}, '{13'h0002, 13'h0002, 1'b1, 16'h1FF8},
      '{13'h0004, 13'h0004, 1'b1, 16'h1FF8}, '{13'h0008, 13'h0008, 1'b1, 16'h1FF6},
      '{13'h0010, 13'h0010, 1'b1, 16'h1FF6}, '{13'h0020, 13'h0020, 1'b1, 16'h1FF6},
      '{13'h0040, 13'h0040, 1'b1, 16'h1FF6}, '{13'h0080, 13'h0080, 1'b1, 16'h1FF6},
      '{13'h0100, 13'h0100, 1'b1, 16'h1FF4}, '{13'h0200, 13'h0100, 1'b1, 16'h1FF4},
      '{13'h0400, 13'h0400, 1'b1, 16'h1FF2}, '{13'h0800, 13'h0800, 1'b1, 16'h1FF0},
      '{13'h1000, 13'h1000, 1'b1, 16'h1FF0}, '{13'h0400, 13'h0400, 1'b0, 16'h0000},
      '{13'h0001, 13'h0000, 1'b1, 16'h0000}, '{13'h1FFF, 13'h1FFF, 1'b1, 16'h1FF8},
      '{13'h1020, 13'h1FFF, 1'b1, 16'h1FF6}};

   irs_sequencer #(.POR_CYCLES(20)) DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
      .reset_pin_b(reset_pin_b), .irq_pin_b(irq_pin_b), .mode_strap(mode_strap), .wdog_enable(wdog_enable),
      .wdog_timeout(wdog_timeout), .instr_done(instr_done), .soft_trap_instr(soft_trap_instr),
      .return_from_trap_instr(return_from_trap_instr), .stop_instr(stop_instr), .wait_instr(wait_instr),
      .mask_set_req(mask_set_req), .mask_clr_req(mask_clr_req), .stack_push_done(stack_push_done),
      .stack_pull_done(stack_pull_done), .restored_mask(restored_mask), .input_capture_flag(flg[0]),
      .output_compare_flag(flg[1]), .timer_one_overflow_flag(flg[2]), .input_capture_en(en[0]),
      .output_compare_en(en[1]), .timer_one_overflow_en(en[2]), .tx_buffer_empty_flag(flg[3]),
      .tx_complete_flag(flg[4]), .rx_buffer_full_flag(flg[5]), .idle_line_flag(flg[6]), .overrun_flag(flg[7]),
      .tx_buffer_empty_en(en[3]), .tx_complete_en(en[4]), .rx_buffer_full_en(en[5]), .idle_line_en(en[6]),
      .overrun_en(en[7]), .sync_transfer_done_flag(flg[8]), .sync_mode_fault_flag(flg[9]), .sync_en(en[8]),
      .twowire_event_flag(flg[10]), .twowire_en(en[10]), .timer_two_overflow_flag(flg[11]),
      .timer_two_tick_flag(flg[12]), .timer_two_overflow_en(en[11]), .timer_two_tick_en(en[12]),
      .timer_two_ctrl_status_reg(timer_two_ctrl_status_alias), .global_mask(global_mask), .core_reset(core_reset),
      .push_regs(push_regs), .pull_regs(pull_regs), .vector_valid(vector_valid), .vector_addr(vector_addr),
      .osc_enable(osc_enable), .cpu_clk_enable(cpu_clk_enable), .timer_clk_enable(timer_clk_enable),
      .op_mode(op_mode));

   irs_core_model core (.clk(clk), .rst_b(rst_b), .push_regs(push_regs), .pull_regs(pull_regs), .slow(slow),
      .stack_push_done(stack_push_done), .stack_pull_done(stack_pull_done));

   always #5 clk = ~clk;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // A fixed window doubles as the proof that nothing was taken when none is expected.
   task automatic grab(output logic [15:0] v);
      v = 16'h0;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge clk);
         #1;
         if (vector_valid === 1'b1 && v === 16'h0)
            v = vector_addr;
      end
   endtask

   task automatic service(input logic [15:0] exp);
      logic [15:0] v;
      @(posedge clk);
      instr_done <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
      #1;
      check("push req", {15'h0, push_regs}, {15'h0, exp !== 16'h0});
      grab(v);
      check("vector", v, exp);
      if (exp !== 16'h0)
         check("mask", {15'h0, global_mask}, 16'h1);
   endtask

   task automatic mask_clear;
      @(posedge clk);
      mask_clr_req <= 1'b1;
      @(posedge clk);
      mask_clr_req <= 1'b0;
      @(posedge clk);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      #100000;
      n_mismatch++;
      results;
   end

   initial
   begin
      {clk, rst_b, wdog_enable, wdog_timeout, instr_done, soft_trap_instr, mode_strap} = 7'h00;
      {return_from_trap_instr, stop_instr, wait_instr, mask_set_req, mask_clr_req, restored_mask, slow} = 7'h00;
      {clk_en, reset_pin_b, irq_pin_b} = 3'h7;
      flg = 13'h0;
      en = 13'h0;
      timer_two_ctrl_status_alias = 8'h00;
      repeat (2) @(posedge clk);
      #1;
      check("reset mask", {15'h0, global_mask}, 16'h1);
      check("reset addr", vector_addr, 16'h1FFE);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check("por hold", {15'h0, core_reset}, 16'h1);
      grab(got);
      check("por vector", got, 16'h1FFE);
      $display("test power_on done");
      for (int i = 0; i < 17; i++)
      begin
         if (rows[i].clr)
            mask_clear;
         @(posedge clk);
         flg <= rows[i].f;
         en <= rows[i].e;
         slow <= i[0];
         service(rows[i].v);
         @(posedge clk);
         flg <= 13'h0;
         en <= 13'h0;
      end
      $display("test source_table done");
      mask_clear;
      @(posedge clk);
      irq_pin_b <= 1'b0;
      flg <= 13'h0001;
      en <= 13'h0001;
      repeat (5) @(posedge clk);
      irq_pin_b <= 1'b1;
      service(16'h1FFA);
      @(posedge clk);
      return_from_trap_instr <= 1'b1;
      @(posedge clk);
      return_from_trap_instr <= 1'b0;
      #1;
      check("pull req", {15'h0, pull_regs}, 16'h1);
      repeat (10) @(posedge clk);
      #1;
      check("restored mask", {15'h0, global_mask}, 16'h0);
      service(16'h1FF8);
      $display("test external_pin done");
      @(posedge clk);
      flg <= 13'h0400;
      en <= 13'h0400;
      mask_clear;
      soft_trap_instr <= 1'b1;
      @(posedge clk);
      soft_trap_instr <= 1'b0;
      service(16'h1FF2);
      service(16'h1FFC);
      flg <= 13'h0;
      $display("test soft_trap done");
      @(posedge clk);
      stop_instr <= 1'b1;
      @(posedge clk);
      stop_instr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("stop osc", {14'h0, osc_enable, global_mask}, 16'h0);
      @(posedge clk);
      irq_pin_b <= 1'b0;
      grab(got);
      check("stop exit", got, 16'h1FFA);
      irq_pin_b <= 1'b1;
      $display("test stop done");
      @(posedge clk);
      wait_instr <= 1'b1;
      @(posedge clk);
      wait_instr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("wait clocks", {14'h0, cpu_clk_enable, timer_clk_enable}, 16'h1);
      @(posedge clk);
      flg <= 13'h1000;
      en <= 13'h1000;
      grab(got);
      check("wait exit", got, 16'h1FF0);
      flg <= 13'h0;
      $display("test wait done");
      // A pin held low in level mode asks again after its service; edge mode would stay quiet.
      @(posedge clk);
      timer_two_ctrl_status_alias <= 8'h08;
      irq_pin_b <= 1'b0;
      mask_clear;
      service(16'h1FFA);
      mask_clear;
      service(16'h1FFA);
      irq_pin_b <= 1'b1;
      timer_two_ctrl_status_alias <= 8'h00;
      $display("test level_trigger done");
      @(posedge clk);
      mode_strap <= 1'b1;
      wdog_enable <= 1'b1;
      wdog_timeout <= 1'b1;
      @(posedge clk);
      wdog_timeout <= 1'b0;
      #1;
      check("wdog reset", {15'h0, core_reset}, 16'h1);
      grab(got);
      check("wdog vector", got, 16'h1FFE);
      check("wdog mode", {15'h0, op_mode}, 16'h0);
      $display("test watchdog done");
      @(posedge clk);
      reset_pin_b <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      check("pin reset", {15'h0, core_reset}, 16'h1);
      reset_pin_b <= 1'b1;
      grab(got);
      check("pin vector", got, 16'h1FFE);
      check("pin mode", {14'h0, op_mode, global_mask}, 16'h3);
      $display("test reset_pin done");
      results;
   end
endmodule
